// file: pkg/fswr_pkg.sv
// Shared constants for the frequency select, watchdog and recovery block
package fswr_pkg;
    // Byte indices of the control bytes
    localparam logic [7:0] FSWR_IDX_STRAP = 8'h07;    // Latched strap code, read only
    localparam logic [7:0] FSWR_IDX_SEL = 8'h08;      // Select code and override
    localparam logic [7:0] FSWR_IDX_WDOG = 8'h09;     // Watchdog arm and time-out status
    localparam logic [7:0] FSWR_IDX_RCV_N = 8'h0b;    // Recovery N value
    localparam logic [7:0] FSWR_IDX_RCV_M = 8'h0c;    // Recovery select and M value
    localparam logic [7:0] FSWR_IDX_CPU_N = 8'h0d;    // Programmed N value
    localparam logic [7:0] FSWR_IDX_CPU_M = 8'h0e;    // Enable and programmed M value
    localparam logic [7:0] FSWR_IDX_SPARE_A = 8'h10;  // Spare control byte A
    localparam logic [7:0] FSWR_IDX_SPARE_B = 8'h11;  // Spare control byte B
    // Field positions
    localparam int FSWR_BIT_OVERRIDE = 7;  // Override in select byte
    localparam int FSWR_BIT_ARM = 0;       // Arm in watchdog byte
    localparam int FSWR_BIT_TIMEOUT = 1;   // Time-out status in watchdog byte
    localparam int FSWR_BIT_ENABLE = 7;    // Enable or recovery select in M bytes
    // Reset values
    localparam logic [7:0] FSWR_RST_BYTE = 8'h00;
    localparam logic [6:0] FSWR_RST_M = 7'h00;
    localparam logic [4:0] FSWR_RST_CODE = 5'h00;
    localparam logic [7:0] FSWR_SPARE_VALUE = 8'h00;  // Spare bytes always read this
    // Gear constant, units of 1e-5
    localparam logic [22:0] FSWR_GEAR = 23'h4940e5;   // 48.00741
    localparam logic [22:0] FSWR_GEAR_NONE = 23'h000000;
    // Timing
    localparam int FSWR_CLK_PERIOD_NS = 40;           // 25 MHz system clock
    localparam int FSWR_WDOG_TIMEOUT_US = 1000000;    // Watchdog time-out, 1 s
    localparam int FSWR_RST_PULSE_US = 10;            // Reset pulse width, 10 us
    localparam int FSWR_WDOG_CYCLES = FSWR_WDOG_TIMEOUT_US * 1000 / FSWR_CLK_PERIOD_NS;
    localparam int FSWR_RST_CYCLES = (FSWR_RST_PULSE_US * 1000 + FSWR_CLK_PERIOD_NS - 1)
        / FSWR_CLK_PERIOD_NS;
    // Watchdog states
    typedef enum logic [2:0] {
        FSWR_W_IDLE = 3'b001,
        FSWR_W_COUNT = 3'b010,
        FSWR_W_RESET = 3'b100
    } fswr_wdog_state_t;
endpackage

// file: design/fswr_strap_latch.sv
// Strap code synchroniser and once-only latch after reset
`timescale 1ns/10ps
`default_nettype none
module fswr_strap_latch
    import fswr_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] strap_pins,
    output logic [WIDTH-1:0] strap_code_r,
    output logic strap_valid_r
);
    logic [WIDTH-1:0] sync1_r, sync2_r, sync3_r;  // Three-stage synchroniser
    logic [WIDTH-1:0] strap_code_nxt;
    logic strap_valid_nxt;

    if (WIDTH < 1) begin : g_bad_width
        $error("strap width must be at least one");
    end

    // Capture once, when the last two stages agree
    always_comb begin
        strap_code_nxt = strap_code_r;
        strap_valid_nxt = strap_valid_r;
        if (!strap_valid_r && sync2_r == sync3_r) begin
            strap_code_nxt = sync3_r;
            strap_valid_nxt = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge sys_clk) begin
        sync1_r <= strap_pins;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
        if (reset) begin
            strap_code_r <= FSWR_RST_CODE;
            strap_valid_r <= 1'b0;
        end else begin
            strap_code_r <= strap_code_nxt;
            strap_valid_r <= strap_valid_nxt;
        end
    end
endmodule // fswr_strap_latch
`default_nettype wire

// file: design/fswr_watchdog.sv
// Watchdog timer with system reset pulse
`timescale 1ns/10ps
`default_nettype none
module fswr_watchdog
    import fswr_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = FSWR_WDOG_CYCLES,
    parameter int PULSE_CYCLES = FSWR_RST_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic arm,
    input wire logic kick,
    output logic expire_r,
    output logic sys_reset_out_r
);
    fswr_wdog_state_t state_r, state_nxt;  // Timer state
    logic [31:0] count_r, count_nxt;       // Cycle counter
    logic expire_nxt, sys_reset_out_nxt;

    if (TIMEOUT_CYCLES < 1 || PULSE_CYCLES < 1) begin : g_bad_count
        $error("watchdog counts must be at least one");
    end

    // Next state: count while armed, then drive reset for the pulse width
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        expire_nxt = 1'b0;
        sys_reset_out_nxt = 1'b0;
        unique case (state_r)
            FSWR_W_IDLE: begin
                count_nxt = 32'h0;
                if (arm) begin
                    state_nxt = FSWR_W_COUNT;
                end
            end
            FSWR_W_COUNT: begin
                if (!arm) begin
                    state_nxt = FSWR_W_IDLE;  // Disarmed
                    count_nxt = 32'h0;
                end else if (kick) begin
                    count_nxt = 32'h0;  // Restart
                end else if (count_r == 32'(TIMEOUT_CYCLES - 1)) begin
                    state_nxt = FSWR_W_RESET;
                    count_nxt = 32'h0;
                    expire_nxt = 1'b1;
                    sys_reset_out_nxt = 1'b1;
                end else begin
                    count_nxt = count_r + 32'h1;
                end
            end
            FSWR_W_RESET: begin
                sys_reset_out_nxt = 1'b1;
                count_nxt = count_r + 32'h1;
                if (count_r == 32'(PULSE_CYCLES - 1)) begin
                    state_nxt = FSWR_W_IDLE;
                    sys_reset_out_nxt = 1'b0;
                    count_nxt = 32'h0;
                end
            end
            default: begin
                state_nxt = FSWR_W_IDLE;
                count_nxt = 32'h0;
            end
        endcase
    end

    // Registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= FSWR_W_IDLE;
            count_r <= 32'h0;
            expire_r <= 1'b0;
            sys_reset_out_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            expire_r <= expire_nxt;
            sys_reset_out_r <= sys_reset_out_nxt;
        end
    end

    // Check helper: high cycles of the current reset pulse so far
    logic [31:0] pulse_len_r, pulse_len_nxt;

    // Next pulse length, cleared while the reset output is low
    always_comb begin
        pulse_len_nxt = sys_reset_out_r ? pulse_len_r + 32'h1 : 32'h0;
    end

    // Pulse length register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pulse_len_r <= 32'h0;
        end else begin
            pulse_len_r <= pulse_len_nxt;
        end
    end

    // Reset pulse ends exactly at the pulse width
    chk_reset_pulse_width: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(sys_reset_out_r) |-> pulse_len_r == 32'(PULSE_CYCLES))
        else $error("reset pulse width wrong");
    // Reset pulse never runs past the pulse width
    chk_reset_pulse_max: assert property (@(posedge sys_clk) disable iff (reset)
        sys_reset_out_r |-> pulse_len_r < 32'(PULSE_CYCLES))
        else $error("reset pulse too long");
endmodule // fswr_watchdog
`default_nettype wire

// file: design/fswr_top.sv
// Frequency select control with watchdog and recovery frequency
// Summary of operation
// - Bytes 16 and 17 read zero, unused.
// - Code decodes to CPU, mid, PCI, gear.
// - Three codes reserved; host must avoid them.
// - Divider mode accepts 50 to 248 MHz.
// - Table mode: strap code unless override set and no time-out.
// - Divider mode ratio/gear from strap or select.
// - Divider mode CPU from N, M, gear.
// - Any N or M write starts reload.
// - Time-out asserts reset, switches to recovery.
// - Recovery select uses recovery N and M.
// - Divider enable resets to zero, disabled.
`timescale 1ns/10ps
`default_nettype none
module fswr_top
    import fswr_pkg::*;
#(
    parameter int WDOG_CYCLES = FSWR_WDOG_CYCLES,  // Time-out length
    parameter int RST_CYCLES = FSWR_RST_CYCLES     // Reset pulse width
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [4:0] strap_freq_code,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_r,
    output logic [11:0] cpu_freq_r,
    output logic [11:0] mid_group_clock_freq_r,
    output logic [11:0] pci_freq_r,
    output logic [22:0] gear_r,
    output logic code_reserved_r,
    output logic divider_mode_r,
    output logic [7:0] pll_n_r,
    output logic [6:0] pll_m_r,
    output logic freq_load_r,
    output logic recovery_active_r,
    output logic sys_reset_out_r
);
    // Control bytes
    logic [4:0] sel_r, sel_nxt;                      // Programmed select code
    logic code_source_override_r, code_source_override_nxt;
    logic [7:0] cpu_divider_n_r, cpu_divider_n_nxt;
    logic [6:0] cpu_divider_m_r, cpu_divider_m_nxt;
    logic prog_en_r, prog_en_nxt;                    // Divider mode enable
    logic [7:0] recovery_divider_n_r, recovery_divider_n_nxt;
    logic [6:0] recovery_divider_m_r, recovery_divider_m_nxt;
    logic recovery_divider_select_r, recovery_divider_select_nxt;
    logic wdog_arm_r, wdog_arm_nxt;                  // Watchdog armed
    logic timeout_r, timeout_nxt;                    // Sticky time-out status
    logic [7:0] reg_rdata_nxt;
    // Outputs next values
    logic [11:0] cpu_freq_nxt, mid_freq_nxt, pci_freq_nxt;
    logic [22:0] gear_nxt;
    logic code_reserved_nxt, divider_mode_nxt, freq_load_nxt;
    logic [7:0] pll_n_nxt;
    logic [6:0] pll_m_nxt;
    // Internal
    logic [4:0] latched_code;   // Strap code after latch
    logic strap_valid;          // Strap capture done
    logic wdog_expire;          // One-cycle time-out event
    logic wdog_kick;            // Watchdog byte written
    logic nm_write;             // Any divider value written
    logic [4:0] active_code;    // Code driving the table
    logic [35:0] table_entry;   // CPU, mid, PCI in 0.1 MHz

    // Table of frequencies in 0.1 MHz steps: cpu, mid group, pci
    function automatic logic [35:0] freq_lookup(input logic [4:0] code);
        unique case (code)
            5'h00: freq_lookup = {12'd1560, 12'd780, 12'd390};
            5'h01: freq_lookup = {12'd1540, 12'd770, 12'd385};
            5'h02: freq_lookup = {12'd1520, 12'd760, 12'd380};
            5'h03: freq_lookup = {12'd1470, 12'd735, 12'd368};
            5'h04: freq_lookup = {12'd1440, 12'd720, 12'd360};
            5'h05: freq_lookup = {12'd1420, 12'd710, 12'd355};
            5'h06: freq_lookup = {12'd1380, 12'd690, 12'd345};
            5'h07: freq_lookup = {12'd1360, 12'd680, 12'd340};
            5'h08: freq_lookup = {12'd1240, 12'd620, 12'd310};
            5'h09: freq_lookup = {12'd1220, 12'd610, 12'd305};
            5'h0a: freq_lookup = {12'd1170, 12'd780, 12'd390};
            5'h0b: freq_lookup = {12'd1150, 12'd767, 12'd383};
            5'h0c: freq_lookup = {12'd1130, 12'd753, 12'd377};
            5'h0d: freq_lookup = {12'd1080, 12'd720, 12'd360};
            5'h0e: freq_lookup = {12'd1050, 12'd700, 12'd350};
            5'h0f: freq_lookup = {12'd1020, 12'd680, 12'd340};
            5'h10, 5'h11, 5'h12: freq_lookup = 36'h0;  // Reserved codes
            5'h13: freq_lookup = {12'd2000, 12'd666, 12'd333};
            5'h14: freq_lookup = {12'd1900, 12'd760, 12'd380};
            5'h15: freq_lookup = {12'd1800, 12'd720, 12'd360};
            5'h16: freq_lookup = {12'd1700, 12'd680, 12'd340};
            5'h17: freq_lookup = {12'd1500, 12'd750, 12'd375};
            5'h18: freq_lookup = {12'd1400, 12'd700, 12'd350};
            5'h19: freq_lookup = {12'd1200, 12'd600, 12'd300};
            5'h1a: freq_lookup = {12'd1100, 12'd733, 12'd333};
            5'h1b: freq_lookup = {12'd666, 12'd666, 12'd333};
            5'h1c: freq_lookup = {12'd2000, 12'd666, 12'd333};
            5'h1d: freq_lookup = {12'd1666, 12'd666, 12'd333};
            5'h1e: freq_lookup = {12'd1000, 12'd666, 12'd333};
            5'h1f: freq_lookup = {12'd1333, 12'd666, 12'd333};
        endcase
    endfunction

    // Strap capture after reset release
    fswr_strap_latch #(
        .WIDTH(5)
    ) u_strap (
        .sys_clk(sys_clk),
        .reset(reset),
        .strap_pins(strap_freq_code),
        .strap_code_r(latched_code),
        .strap_valid_r(strap_valid)
    );

    // Watchdog timer
    fswr_watchdog #(
        .TIMEOUT_CYCLES(WDOG_CYCLES),
        .PULSE_CYCLES(RST_CYCLES)
    ) u_wdog (
        .sys_clk(sys_clk),
        .reset(reset),
        .arm(wdog_arm_r),
        .kick(wdog_kick),
        .expire_r(wdog_expire),
        .sys_reset_out_r(sys_reset_out_r)
    );

    assign wdog_kick = reg_wr_en && reg_addr == FSWR_IDX_WDOG;
    assign nm_write = reg_wr_en && (reg_addr == FSWR_IDX_CPU_N || reg_addr == FSWR_IDX_CPU_M
        || reg_addr == FSWR_IDX_RCV_N || reg_addr == FSWR_IDX_RCV_M);

    // Register writes; spare bytes take no write
    always_comb begin
        sel_nxt = sel_r;
        code_source_override_nxt = code_source_override_r;
        cpu_divider_n_nxt = cpu_divider_n_r;
        cpu_divider_m_nxt = cpu_divider_m_r;
        prog_en_nxt = prog_en_r;
        recovery_divider_n_nxt = recovery_divider_n_r;
        recovery_divider_m_nxt = recovery_divider_m_r;
        recovery_divider_select_nxt = recovery_divider_select_r;
        wdog_arm_nxt = wdog_arm_r;
        timeout_nxt = timeout_r;
        if (reg_wr_en) begin
            unique case (reg_addr)
                FSWR_IDX_SEL: begin
                    sel_nxt = reg_wdata[4:0];
                    code_source_override_nxt = reg_wdata[FSWR_BIT_OVERRIDE];
                end
                FSWR_IDX_WDOG: begin
                    wdog_arm_nxt = reg_wdata[FSWR_BIT_ARM];
                    if (reg_wdata[FSWR_BIT_TIMEOUT]) begin
                        timeout_nxt = 1'b0;  // Write one clears
                    end
                end
                FSWR_IDX_CPU_N: cpu_divider_n_nxt = reg_wdata;
                FSWR_IDX_CPU_M: begin
                    cpu_divider_m_nxt = reg_wdata[6:0];
                    prog_en_nxt = reg_wdata[FSWR_BIT_ENABLE];
                end
                FSWR_IDX_RCV_N: recovery_divider_n_nxt = reg_wdata;
                FSWR_IDX_RCV_M: begin
                    recovery_divider_m_nxt = reg_wdata[6:0];
                    recovery_divider_select_nxt = reg_wdata[FSWR_BIT_ENABLE];
                end
                default: begin
                    // Spare and unmapped bytes ignore writes
                end
            endcase
        end
        if (wdog_expire) begin
            timeout_nxt = 1'b1;    // Set wins over clear
            wdog_arm_nxt = 1'b0;   // One-shot after time-out
        end
    end

    // Read data, spare and unmapped bytes read zero
    always_comb begin
        reg_rdata_nxt = reg_rdata_r;
        if (reg_rd_en) begin
            unique case (reg_addr)
                FSWR_IDX_STRAP: reg_rdata_nxt = {3'h0, latched_code};
                FSWR_IDX_SEL: reg_rdata_nxt = {code_source_override_r, 2'h0, sel_r};
                FSWR_IDX_WDOG: reg_rdata_nxt = {6'h0, timeout_r, wdog_arm_r};
                FSWR_IDX_CPU_N: reg_rdata_nxt = cpu_divider_n_r;
                FSWR_IDX_CPU_M: reg_rdata_nxt = {prog_en_r, cpu_divider_m_r};
                FSWR_IDX_RCV_N: reg_rdata_nxt = recovery_divider_n_r;
                FSWR_IDX_RCV_M: reg_rdata_nxt = {recovery_divider_select_r, recovery_divider_m_r};
                default: reg_rdata_nxt = FSWR_SPARE_VALUE;
            endcase
        end
    end

    // Code source: strap during recovery, else strap or select by override
    always_comb begin
        if (timeout_r || !code_source_override_r) begin
            active_code = latched_code;
        end else begin
            active_code = sel_r;
        end
        table_entry = freq_lookup(active_code);
    end

    // Output selection
    always_comb begin
        cpu_freq_nxt = table_entry[35:24];
        mid_freq_nxt = table_entry[23:12];
        pci_freq_nxt = table_entry[11:0];
        code_reserved_nxt = (table_entry == 36'h0);
        gear_nxt = code_reserved_nxt ? FSWR_GEAR_NONE : FSWR_GEAR;
        // N and M pass unclamped, so any target in range is served
        if (timeout_r) begin
            divider_mode_nxt = recovery_divider_select_r;
            pll_n_nxt = recovery_divider_n_r;
            pll_m_nxt = recovery_divider_m_r;
        end else begin
            divider_mode_nxt = prog_en_r;
            pll_n_nxt = cpu_divider_n_r;
            pll_m_nxt = cpu_divider_m_r;
        end
        // Reload on any single N or M write, and on time-out
        freq_load_nxt = nm_write || wdog_expire;
    end

    // Registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sel_r <= FSWR_RST_CODE;
            code_source_override_r <= 1'b0;
            cpu_divider_n_r <= FSWR_RST_BYTE;
            cpu_divider_m_r <= FSWR_RST_M;
            prog_en_r <= 1'b0;
            recovery_divider_n_r <= FSWR_RST_BYTE;
            recovery_divider_m_r <= FSWR_RST_M;
            recovery_divider_select_r <= 1'b0;
            wdog_arm_r <= 1'b0;
            timeout_r <= 1'b0;
            reg_rdata_r <= FSWR_RST_BYTE;
            cpu_freq_r <= 12'h0;
            mid_group_clock_freq_r <= 12'h0;
            pci_freq_r <= 12'h0;
            gear_r <= FSWR_GEAR_NONE;
            code_reserved_r <= 1'b0;
            divider_mode_r <= 1'b0;
            pll_n_r <= FSWR_RST_BYTE;
            pll_m_r <= FSWR_RST_M;
            freq_load_r <= 1'b0;
            recovery_active_r <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
            code_source_override_r <= code_source_override_nxt;
            cpu_divider_n_r <= cpu_divider_n_nxt;
            cpu_divider_m_r <= cpu_divider_m_nxt;
            prog_en_r <= prog_en_nxt;
            recovery_divider_n_r <= recovery_divider_n_nxt;
            recovery_divider_m_r <= recovery_divider_m_nxt;
            recovery_divider_select_r <= recovery_divider_select_nxt;
            wdog_arm_r <= wdog_arm_nxt;
            timeout_r <= timeout_nxt;
            reg_rdata_r <= reg_rdata_nxt;
            cpu_freq_r <= cpu_freq_nxt;
            mid_group_clock_freq_r <= mid_freq_nxt;
            pci_freq_r <= pci_freq_nxt;
            gear_r <= gear_nxt;
            code_reserved_r <= code_reserved_nxt;
            divider_mode_r <= divider_mode_nxt;
            pll_n_r <= pll_n_nxt;
            pll_m_r <= pll_m_nxt;
            freq_load_r <= freq_load_nxt;
            recovery_active_r <= timeout_r;
        end
    end

    // Checks
    chk_spare_read_zero: assert property (@(posedge sys_clk) disable iff (reset)
        reg_rd_en && (reg_addr == FSWR_IDX_SPARE_A || reg_addr == FSWR_IDX_SPARE_B)
        |=> reg_rdata_r == FSWR_SPARE_VALUE)
        else $error("spare byte read not zero");
    chk_top_code_decode: assert property (@(posedge sys_clk) disable iff (reset)
        active_code == 5'h1f |=> cpu_freq_r == 12'd1333 && mid_group_clock_freq_r == 12'd666
        && pci_freq_r == 12'd333 && gear_r == FSWR_GEAR)
        else $error("code 11111 decoded wrongly");
    chk_reserved_flag: assert property (@(posedge sys_clk) disable iff (reset)
        active_code inside {5'h10, 5'h11, 5'h12} |=> code_reserved_r && cpu_freq_r == 12'h0)
        else $error("reserved code not flagged");
    chk_override_source: assert property (@(posedge sys_clk) disable iff (reset)
        !timeout_r && code_source_override_r |-> active_code == sel_r)
        else $error("override did not select programmed code");
    chk_strap_source: assert property (@(posedge sys_clk) disable iff (reset)
        !code_source_override_r |-> active_code == latched_code)
        else $error("strap code not used without override");
    chk_divider_values: assert property (@(posedge sys_clk) disable iff (reset)
        !timeout_r && prog_en_r |=> divider_mode_r && pll_n_r == $past(cpu_divider_n_r))
        else $error("divider mode values not applied");
    chk_single_write_load: assert property (@(posedge sys_clk) disable iff (reset)
        reg_wr_en && reg_addr == FSWR_IDX_CPU_N |=> freq_load_r)
        else $error("N write did not start reload");
    chk_timeout_recovery: assert property (@(posedge sys_clk) disable iff (reset)
        wdog_expire |-> sys_reset_out_r ##1 timeout_r ##1 recovery_active_r)
        else $error("time-out did not reset and recover");
    chk_recovery_values: assert property (@(posedge sys_clk) disable iff (reset)
        timeout_r && recovery_divider_select_r |=> divider_mode_r
        && pll_m_r == $past(recovery_divider_m_r))
        else $error("recovery divider values not applied");
    chk_enable_reset: assert property (@(posedge sys_clk)
        reset |=> !prog_en_r && !divider_mode_r)
        else $error("divider enable not cleared by reset");
endmodule // fswr_top
`default_nettype wire

// file: verification/fswr_host_model.sv
// Register host model driving the byte strobes
`timescale 1ns/10ps
`default_nettype none
module fswr_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata_r,
    output var logic reg_wr_en,
    output var logic reg_rd_en,
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata
);
    // Quiet bus at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One byte write, strobe stays up for a following byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
    endtask
    // Release strobes, scramble stale address and data
    task automatic idle();
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
    // Divider pair in consecutive cycles
    task automatic wr_nm(input logic [7:0] n, input logic [7:0] m);
        wr(8'h0d, n);
        wr(8'h0e, m);
        idle();
    endtask
    // Byte read, data taken after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        idle();
        d = reg_rdata_r;
    endtask
endmodule // fswr_host_model
`default_nettype wire

// file: verification/fswr_top_tb_top.sv
// Self-checking bench for the frequency select block
`timescale 1ns/10ps
`default_nettype none
module fswr_top_tb_top import fswr_pkg::*;;
    typedef struct packed {logic [4:0] code; logic [11:0] cpu, mid, pci; logic rsv;} fswr_row_t;
    localparam int PULSE = 3;  // Short reset pulse
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] strap_freq_code = 5'h1d;  // Strap selects 166.6
    logic reg_wr_en, reg_rd_en, rsv, div_mode, load, rcv, rst_out;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_r, rd_val, pll_n;
    logic [11:0] cpu_f, mid_f, pci_f;
    logic [22:0] gear;
    logic [6:0] pll_m;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    int loads = 0;
    int loads0 = 0;
    int width = 0;
    // Select codes with expected table outputs, 0.1 MHz units
    fswr_row_t rows [8] = '{'{5'h00, 12'h618, 12'h30c, 12'h186, 1'b0},
        '{5'h03, 12'h5be, 12'h2df, 12'h170, 1'b0}, '{5'h1f, 12'h535, 12'h29a, 12'h14d, 1'b0},
        '{5'h10, 12'h000, 12'h000, 12'h000, 1'b1}, '{5'h12, 12'h000, 12'h000, 12'h000, 1'b1},
        '{5'h13, 12'h7d0, 12'h29a, 12'h14d, 1'b0}, '{5'h1b, 12'h29a, 12'h29a, 12'h14d, 1'b0},
        '{5'h0b, 12'h47e, 12'h2ff, 12'h17f, 1'b0}};
    fswr_top #(.WDOG_CYCLES(20), .RST_CYCLES(PULSE)) uut (.sys_clk(sys_clk), .reset(reset),
        .strap_freq_code(strap_freq_code), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .cpu_freq_r(cpu_f), .mid_group_clock_freq_r(mid_f), .pci_freq_r(pci_f), .gear_r(gear),
        .code_reserved_r(rsv), .divider_mode_r(div_mode), .pll_n_r(pll_n), .pll_m_r(pll_m),
        .freq_load_r(load), .recovery_active_r(rcv), .sys_reset_out_r(rst_out));
    fswr_host_model host (.sys_clk(sys_clk), .reg_rdata_r(reg_rdata_r), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask
    // Verdict and end of run
    task automatic give_verdict();
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always #20 sys_clk = ~sys_clk;
    // Load pulse counter and hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (load === 1'b1) loads <= loads + 1;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        repeat (6) @(negedge sys_clk);
        check(cpu_f, 12'h682, "strap cpu");
        check(div_mode, 1'b0, "divider off");
        host.rd(FSWR_IDX_CPU_M, rd_val);
        check(rd_val, 8'h00, "enable byte");
        // Spare bytes ignore writes
        host.wr(FSWR_IDX_SPARE_A, 8'hff);
        host.wr(FSWR_IDX_SPARE_B, 8'hff);
        host.idle();
        host.rd(FSWR_IDX_SPARE_A, rd_val);
        check(rd_val, 8'h00, "spare a");
        host.rd(FSWR_IDX_SPARE_B, rd_val);
        check(rd_val, 8'h00, "spare b");
        // Table rows through the select field with override set
        foreach (rows[i]) begin
            host.wr(FSWR_IDX_SEL, {3'h4, rows[i].code});
            host.idle();
            repeat (3) @(negedge sys_clk);
            check(rsv, rows[i].rsv, "reserved flag");
            check(gear, rows[i].rsv ? FSWR_GEAR_NONE : FSWR_GEAR, "gear");
            if (!rows[i].rsv) begin
                check(cpu_f, rows[i].cpu, "cpu");
                check(mid_f, rows[i].mid, "mid");
                check(pci_f, rows[i].pci, "pci");
            end
        end
        // Divider mode, top of the range
        loads0 = loads;
        host.wr_nm(8'hf8, 8'h85);
        repeat (3) @(negedge sys_clk);
        check(loads - loads0, 2, "one load per byte");
        check(div_mode, 1'b1, "divider on");
        check(pll_n, 8'hf8, "n in use");
        check(pll_m, 7'h05, "m in use");
        check(mid_f, 12'h2ff, "ratio from select");
        check(gear, FSWR_GEAR, "divider gear");
        // Watchdog expiry with recovery pair
        host.wr(FSWR_IDX_RCV_N, 8'h22);
        host.wr(FSWR_IDX_RCV_M, 8'h83);
        host.wr(FSWR_IDX_WDOG, 8'h01);
        host.idle();
        for (int i = 0; i < 200 && rst_out !== 1'b1; i++) @(negedge sys_clk);
        while (rst_out === 1'b1 && width < 10) begin
            width++;
            @(negedge sys_clk);
        end
        check(width, PULSE, "reset pulse");
        check(rcv, 1'b1, "recovery active");
        check(pll_n, 8'h22, "recovery n");
        check(pll_m, 7'h03, "recovery m");
        check(cpu_f, 12'h682, "recovery code");
        host.rd(FSWR_IDX_WDOG, rd_val);
        check(rd_val[1], 1'b1, "timeout status");
        host.wr(FSWR_IDX_WDOG, 8'h02);
        host.idle();
        repeat (3) @(negedge sys_clk);
        check(rcv, 1'b0, "status cleared");
        give_verdict();
    end
endmodule // fswr_top_tb_top
`default_nettype wire
